// [logic/ind_pin_drive.sv]
// Purpose: output stage of one indicator pin
// Assumes: level_in is the wanted pin level, same clock
// Notes: invalid drive codes release the pin
`timescale 1ns/1ps
module ind_pin_drive
	import ind_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       level_in,
	input  wire logic [1:0] drive_in,
	output logic            pin_out,
	output logic            pin_oe_out
);
	wire is_pp = (drive_in == DRV_PP);
	wire is_od = (drive_in == DRV_OD);
	// open drain drives only the low level, a high level is released
	wire out_nxt = is_pp & level_in;
	wire oe_nxt = is_pp | (is_od & ~level_in);

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pin_out <= 1'b0;
			pin_oe_out <= 1'b0;
		end
		else
		begin
			pin_out <= out_nxt;
			pin_oe_out <= oe_nxt;
		end
	end
endmodule

// [logic/ind_pkg.sv]
// Purpose: constants for the usb indicator pin block
// Assumes: apb register access, 32-bit data, one aligned word per register
// Notes: printed offsets are word indices; byte address is four times that
// Notes on behaviour
// - bit 13 reads pin b level
// - pin b select 000: high on suspend/reset
// - pin b 001 high, 101 low, suspend only
// - 010/110 add unconfigured for high power
// - pin b 011 high, 111 low, reset only
// - pin b select 100: high on suspend/reset
// - pin b drive bits 9:8, default push-pull
// - bit 5 reads pin a level
// - pin a select 000: low on suspend/reset
// - pin a 001/010/011 assert high
// - pin a 100..111 assert low
// - pin a drive: 01 open drain, 10 push-pull
package ind_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h262;
	localparam logic [ADDR_W-1:0] CLASS_IDX = 12'h263;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'(CTRL_IDX * 4);
	localparam logic [ADDR_W-1:0] CLASS_ADDR = 12'(CLASS_IDX * 4);
	localparam int B_LEVEL_BIT = 13;
	localparam int B_SEL_LSB = 10;
	localparam int B_DRV_LSB = 8;
	localparam int A_LEVEL_BIT = 5;
	localparam int A_SEL_LSB = 2;
	localparam int A_DRV_LSB = 0;
	localparam int CLASS_BIT = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h1F1F;
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic [1:0] DRV_RST = 2'h2;
	localparam logic [1:0] DRV_OD = 2'h1;
	localparam logic [1:0] DRV_PP = 2'h2;
	localparam logic CLASS_RST = 1'b0;
	typedef enum logic [1:0] {
		COND_SUSP_RST,
		COND_SUSP,
		COND_SUSP_UNCFG,
		COND_RST
	} cond_t;
endpackage

// [logic/level_sync.sv]
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: one clock, synchronous active-high reset
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
module level_sync
	import ind_pkg::*;
#(
	parameter int WIDTH = 2
)
(
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// [logic/usb_indicator_pins.sv]
// Purpose: two usb state indicator pins with apb control register
// Assumes: usb state inputs come from logic on clk_in
// Notes: one wait state on every apb access
`timescale 1ns/1ps
module usb_indicator_pins
	import ind_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	input  wire logic [3:0]        pstrb_in,
	output logic                   pready_out,
	output logic      [31:0]       prdata_out,
	output logic                   pslverr_out,
	input  wire logic              suspend_in,
	input  wire logic              bus_reset_in,
	input  wire logic              configured_in,
	input  wire logic              indicator_pin_a_in,
	output logic                   indicator_pin_a_out,
	output logic                   indicator_pin_a_oe_out,
	input  wire logic              indicator_pin_b_in,
	output logic                   indicator_pin_b_out,
	output logic                   indicator_pin_b_oe_out
);
	// control fields
	logic [2:0] pin_a_condition_select_r;
	logic [2:0] pin_b_condition_select_r;
	logic [1:0] pin_a_drive_type_r;
	logic [1:0] pin_b_drive_type_r;
	logic       high_power_r;
	logic       pready_r;
	logic [31:0] prdata_r;
	logic       pslverr_r;

	// synchronised pin levels
	logic [1:0] pin_level_sync;
	wire pin_a_level = pin_level_sync[0];
	wire pin_b_level = pin_level_sync[1];

	level_sync #(
		.WIDTH (2)
	) u_level_sync (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({indicator_pin_b_in, indicator_pin_a_in}),
		.sync_out   (pin_level_sync)
	);

	// apb decode
	wire access = psel_in & penable_in;
	wire hit_ctrl = (paddr_in == CTRL_ADDR);
	wire hit_class = (paddr_in == CLASS_ADDR);
	wire mapped = hit_ctrl | hit_class;
	wire done = access & pready_r;
	wire wr_ctrl = done & pwrite_in & hit_ctrl;
	wire wr_class = done & pwrite_in & hit_class;

	// byte lane write mask, reserved bits never stored
	wire [15:0] lane_mask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
	wire [15:0] wr_mask = lane_mask & CTRL_WMASK;
	wire [15:0] ctrl_old = {
		3'h0,
		pin_b_condition_select_r,
		pin_b_drive_type_r,
		3'h0,
		pin_a_condition_select_r,
		pin_a_drive_type_r
	};
	wire [15:0] ctrl_new = (pwdata_in[15:0] & wr_mask)
		| (ctrl_old & ~wr_mask);

	// next values of control fields
	wire [2:0] pin_a_condition_select_nxt = wr_ctrl
		? ctrl_new[A_SEL_LSB +: 3] : pin_a_condition_select_r;
	wire [2:0] pin_b_condition_select_nxt = wr_ctrl
		? ctrl_new[B_SEL_LSB +: 3] : pin_b_condition_select_r;
	wire [1:0] pin_a_drive_type_nxt = wr_ctrl
		? ctrl_new[A_DRV_LSB +: 2] : pin_a_drive_type_r;
	wire [1:0] pin_b_drive_type_nxt = wr_ctrl
		? ctrl_new[B_DRV_LSB +: 2] : pin_b_drive_type_r;
	wire high_power_nxt = (wr_class & pstrb_in[0])
		? pwdata_in[CLASS_BIT] : high_power_r;

	// read data
	logic [15:0] ctrl_rd;
	always_comb
	begin
		ctrl_rd = ctrl_old;
		ctrl_rd[B_LEVEL_BIT] = pin_b_level;
		ctrl_rd[A_LEVEL_BIT] = pin_a_level;
	end

	wire [31:0] class_rd = {31'h0, high_power_r};
	wire [31:0] rd_word = hit_ctrl ? {16'h0, ctrl_rd}
		: (hit_class ? class_rd : 32'h0);

	wire pready_nxt = access & ~pready_r;
	wire [31:0] prdata_nxt = (pready_nxt & ~pwrite_in) ? rd_word
		: 32'h0;
	wire pslverr_nxt = pready_nxt & ~mapped;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pin_a_condition_select_r <= SEL_RST;
			pin_b_condition_select_r <= SEL_RST;
			pin_a_drive_type_r <= DRV_RST;
			pin_b_drive_type_r <= DRV_RST;
			high_power_r <= CLASS_RST;
		end
		else
		begin
			pin_a_condition_select_r <= pin_a_condition_select_nxt;
			pin_b_condition_select_r <= pin_b_condition_select_nxt;
			pin_a_drive_type_r <= pin_a_drive_type_nxt;
			pin_b_drive_type_r <= pin_b_drive_type_nxt;
			high_power_r <= high_power_nxt;
		end
	end

	assign pready_out = pready_r;
	assign prdata_out = prdata_r;
	assign pslverr_out = pslverr_r;

	// condition terms shared by both pins
	wire susp_or_rst = suspend_in | bus_reset_in;
	wire unconfig_hp = high_power_r & ~configured_in;
	wire susp_or_uncfg = suspend_in | unconfig_hp;

	// per pin condition select and polarity
	logic [2:0] sel_v [2];
	logic [1:0] drv_v [2];
	logic [1:0] active_high;
	logic [1:0] cond_hit;
	logic [1:0] pin_level;
	logic [1:0] pin_out_v;
	logic [1:0] pin_oe_v;

	assign sel_v[0] = pin_a_condition_select_r;
	assign sel_v[1] = pin_b_condition_select_r;
	assign drv_v[0] = pin_a_drive_type_r;
	assign drv_v[1] = pin_b_drive_type_r;

	// pin a asserts high only for 001..011
	assign active_high[0] = (sel_v[0] == 3'h1)
		| (sel_v[0] == 3'h2)
		| (sel_v[0] == 3'h3);
	// pin b asserts high for 000..100
	assign active_high[1] = ~sel_v[1][2]
		| (sel_v[1] == 3'h4);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			cond_t cond;
			assign cond = cond_t'(sel_v[g][1:0]);

			always_comb
			begin
				case (cond)
					COND_SUSP_RST:
						cond_hit[g] = susp_or_rst;
					COND_SUSP:
						cond_hit[g] = suspend_in;
					COND_SUSP_UNCFG:
						cond_hit[g] = susp_or_uncfg;
					COND_RST:
						cond_hit[g] = bus_reset_in;
					default:
						cond_hit[g] = 1'b0;
				endcase
			end

			// asserted level when hit, the inverse level when idle
			assign pin_level[g] = cond_hit[g]
				? active_high[g] : ~active_high[g];

			ind_pin_drive u_drive (
				.clk_in     (clk_in),
				.sys_rst_in (sys_rst_in),
				.level_in   (pin_level[g]),
				.drive_in   (drv_v[g]),
				.pin_out    (pin_out_v[g]),
				.pin_oe_out (pin_oe_v[g])
			);
		end
	endgenerate

	assign indicator_pin_a_out = pin_out_v[0];
	assign indicator_pin_a_oe_out = pin_oe_v[0];
	assign indicator_pin_b_out = pin_out_v[1];
	assign indicator_pin_b_oe_out = pin_oe_v[1];
endmodule

// [test/pin_load.sv]
// Purpose: board load on the two indicator pins
// Assumes: pull-up resistor on each pin
// Notes: a released pin reads high
`timescale 1ns/1ps
module pin_load
(
	input  wire logic a_out_in,
	input  wire logic a_oe_in,
	input  wire logic b_out_in,
	input  wire logic b_oe_in,
	output logic      a_lvl_out,
	output logic      b_lvl_out
);
	// released pin is pulled high
	assign a_lvl_out = a_oe_in ? a_out_in : 1'b1;
	assign b_lvl_out = b_oe_in ? b_out_in : 1'b1;
endmodule

// [test/tb.sv]
// Purpose: self-checking bench for the indicator pins
// Assumes: pull-up load on both pins
// Notes: one task per scenario
`timescale 1ns/1ps
module tb
	import ind_pkg::*;
;
	logic              clk_in = 1'b0;
	logic              rst    = 1'b1;
	logic              psel   = 1'b0;
	logic              pen    = 1'b0;
	logic              pwr    = 1'b0;
	logic [ADDR_W-1:0] padr   = '0;
	logic [31:0]       pwd    = '0;
	logic [3:0]        pstb   = 4'hF;
	logic              susp   = 1'b0;
	logic              brst   = 1'b0;
	logic              cfg    = 1'b0;
	logic              prdy, perr, a_o, a_oe, b_o, b_oe, a_l, b_l, er;
	logic [31:0]       prd, rd;
	int                err_count = 0;
	int                compares  = 0;
	always #20 clk_in = ~clk_in;
	usb_indicator_pins DUT (.clk_in(clk_in), .sys_rst_in(rst),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(padr), .pwdata_in(pwd), .pstrb_in(pstb),
		.pready_out(prdy), .prdata_out(prd), .pslverr_out(perr),
		.suspend_in(susp), .bus_reset_in(brst), .configured_in(cfg),
		.indicator_pin_a_in(a_l), .indicator_pin_a_out(a_o),
		.indicator_pin_a_oe_out(a_oe), .indicator_pin_b_in(b_l),
		.indicator_pin_b_out(b_o), .indicator_pin_b_oe_out(b_oe));
	pin_load u_load (.a_out_in(a_o), .a_oe_in(a_oe), .b_out_in(b_o),
		.b_oe_in(b_oe), .a_lvl_out(a_l), .b_lvl_out(b_l));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk_in);
		pen <= 1'b1;
		do @(posedge clk_in); while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	function automatic logic lvl(input logic b, input logic [2:0] s,
		input logic hp, input logic [2:0] c);
		logic act;
		logic hi;
		case (s[1:0])
			2'h0: act = c[2] | c[1];
			2'h1: act = c[2];
			2'h2: act = c[2] | (hp & ~c[0]);
			default: act = c[1];
		endcase
		hi = b ? (!s[2] || s == 3'h4) : (s != 3'h0 && !s[2]);
		return hi ? act : !act;
	endfunction
	task automatic t_reset();
		apb(1'b0, CTRL_ADDR, 32'h0);
		chk(rd, 32'h0222);
		chk(32'({a_oe, a_o, b_oe, b_o}), 32'hE);
		apb(1'b0, CLASS_ADDR, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_select();
		logic ea;
		logic eb;
		for (int hp = 0; hp < 2; hp++)
		begin
			apb(1'b1, CLASS_ADDR, 32'(hp));
			for (int s = 0; s < 8; s++)
			begin
				apb(1'b1, CTRL_ADDR, 32'(s * 16'h0404 + 16'h0202));
				for (int c = 0; c < 8; c++)
				begin
					@(posedge clk_in);
					{susp, brst, cfg} <= 3'(c);
					repeat (4) @(posedge clk_in);
					ea = lvl(1'b0, 3'(s), hp[0], 3'(c));
					eb = lvl(1'b1, 3'(s), hp[0], 3'(c));
					apb(1'b0, CTRL_ADDR, 32'h0);
					chk(32'(b_o), 32'(eb));
					chk(32'(a_o), 32'(ea));
					chk(32'({rd[13], rd[5]}), 32'({eb, ea}));
				end
			end
		end
	endtask
	task automatic t_drive();
		logic [1:0] d;
		logic [1:0] e;
		logic       r;
		for (int i = 0; i < 8; i++)
		begin
			d = 2'(i);
			apb(1'b1, CTRL_ADDR, 32'({6'h01, d, 6'h01, d}));
			@(posedge clk_in);
			susp <= i[2];
			repeat (4) @(posedge clk_in);
			e = d == DRV_PP ? {1'b1, i[2]} : d == DRV_OD ? {!i[2], 1'b0} : 2'h0;
			chk(32'({a_oe, a_o, b_oe, b_o}), 32'({e, e}));
			// released pins read back high through the pull-up
			apb(1'b0, CTRL_ADDR, 32'h0);
			r = (d == DRV_PP || d == DRV_OD) ? i[2] : 1'b1;
			chk(32'({rd[13], rd[5]}), 32'({r, r}));
		end
	endtask
	task automatic t_bad();
		apb(1'b1, CTRL_ADDR, 32'h1F1F);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk({rd[31:1], er}, 32'h1);
		apb(1'b0, CTRL_ADDR, 32'h0);
		chk(rd & 32'hDFDF, 32'h1F1F);
		// low byte lane only: pin a fields cleared, pin b kept
		pstb <= 4'h1;
		apb(1'b1, CTRL_ADDR, 32'h0);
		pstb <= 4'hF;
		apb(1'b0, CTRL_ADDR, 32'h0);
		chk(rd & 32'hDFDF, 32'h1F00);
	endtask
	task automatic t_rerun();
		rst <= 1'b1;
		susp <= 1'b0;
		brst <= 1'b0;
		repeat (5) @(posedge clk_in);
		rst <= 1'b0;
		repeat (6) @(posedge clk_in);
		t_reset();
	endtask
	task automatic final_report();
		$display("err_count %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk_in);
		rst <= 1'b0;
		repeat (6) @(posedge clk_in);
		t_reset();
		t_select();
		t_drive();
		t_bad();
		t_rerun();
		final_report();
	end
	initial
	begin
		#800000;
		err_count++;
		final_report();
	end
endmodule

// [test/usb_indicator_pins_checker.sv]
// Purpose: port checks for the indicator pin block
// Assumes: bound to usb_indicator_pins
// Notes: apb answer and pin release
`timescale 1ns/1ps
module usb_indicator_pins_checker
	import ind_pkg::*;
(
	input wire logic              clk_in,
	input wire logic              sys_rst_in,
	input wire logic              psel_in,
	input wire logic              penable_in,
	input wire logic              pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic              pready_out,
	input wire logic [31:0]       prdata_out,
	input wire logic              pslverr_out,
	input wire logic              indicator_pin_a_out,
	input wire logic              indicator_pin_a_oe_out,
	input wire logic              indicator_pin_b_out,
	input wire logic              indicator_pin_b_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	chk_ready_cause: assert property (
		pready_out |-> $past(psel_in & penable_in))
		else $error("pready without access");
	chk_ready_wait: assert property (
		psel_in && penable_in && !$past(penable_in) |=> pready_out)
		else $error("pready late");
	chk_ready_pulse: assert property (
		pready_out |=> !pready_out) else $error("pready too long");
	chk_err_decode: assert property (
		pready_out |-> pslverr_out ==
		(paddr_in != CTRL_ADDR && paddr_in != CLASS_ADDR))
		else $error("pslverr wrong");
	chk_data_idle: assert property (
		!pready_out || pslverr_out |-> prdata_out == 32'h0)
		else $error("prdata not zero");
	chk_resv_zero: assert property (
		pready_out |-> prdata_out[31:14] == 18'h0
		&& prdata_out[7:6] == 2'h0) else $error("reserved bits set");
	chk_a_release: assert property (
		!indicator_pin_a_oe_out |-> !indicator_pin_a_out)
		else $error("pin a driven while released");
	chk_b_release: assert property (
		!indicator_pin_b_oe_out |-> !indicator_pin_b_out)
		else $error("pin b driven while released");
	chk_rst_clear: assert property (
		$fell(sys_rst_in) |-> !indicator_pin_a_oe_out
		&& !indicator_pin_b_oe_out && !pready_out)
		else $error("outputs not cleared");
	cov_err: cover property (pslverr_out);
	cov_read: cover property (pready_out && !pwrite_in);
	cov_od: cover property (!indicator_pin_b_oe_out);
endmodule
bind usb_indicator_pins usb_indicator_pins_checker u_chk (
	.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .pready_out, .prdata_out, .pslverr_out,
	.indicator_pin_a_out, .indicator_pin_a_oe_out,
	.indicator_pin_b_out, .indicator_pin_b_oe_out
);
